// [logic/command_source_selector.v]
// Behaviour
// - frequency and run sources chosen independently; link mode and fieldbus mode
// - link mode codes 0..8 map to local/standard/extension source pairs
// - fieldbus mode codes 0..3 put neither, frequency, run or both on the field bus
// - fieldbus assignment overrides link mode for that command only
// - local run source comes from keypad or terminals per run-origin setting
// - local frequency from frequency settings or multistep selection
// - standard link via keypad port, extension link via extension card
// - permit input assigned and open: both commands taken from the drive itself
// - frequency link may read status and parameters and set frequency; run link may issue run
//
// Strobed register access and the address map were decided locally.
`default_nettype none
`include "source_sel_regs.vh"

module command_source_selector
(
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        resetn_i,
    // register port
    input  wire [3:0]  addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    // permit terminal, high when shorted to common
    input  wire        remote_permit_input_i,
    // local command inputs
    input  wire [15:0] local_freq_i,
    input  wire [15:0] multistep_freq_i,
    input  wire        multistep_sel_i,
    input  wire        keypad_run_i,
    input  wire        terminal_run_i,
    // standard link (keypad port) commands
    input  wire [15:0] std_freq_i,
    input  wire        std_run_i,
    // extension card link commands
    input  wire [15:0] ext_freq_i,
    input  wire        ext_run_i,
    // field bus commands
    input  wire [15:0] fbus_freq_i,
    input  wire        fbus_run_i,
    // selected commands and sources
    output reg  [15:0] freq_cmd_o,
    output reg         run_cmd_o,
    output reg  [1:0]  freq_src_o,
    output reg  [1:0]  run_src_o,
    output reg  [1:0]  monitor_grant_o
);

    // =========================================================
    // configuration registers
    reg  [3:0] link_source_select_reg;
    reg  [1:0] fieldbus_source_select_reg;
    reg        run_origin_param_reg;     // 0 keypad, 1 terminals
    reg        permit_assigned_reg;
    reg  [1:0] permit_sync_reg;
    reg  [1:0] terminal_sync_reg;
    wire       permit_level;

    // permit pin passes two flops before use
    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            permit_sync_reg <= `SYNC_RST;
        else
            permit_sync_reg <= {permit_sync_reg[0], remote_permit_input_i};
    end
    assign permit_level = permit_sync_reg[1];

    // terminal run level is a pin as well; same two-flop treatment as the permit
    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            terminal_sync_reg <= `SYNC_RST;
        else
            terminal_sync_reg <= {terminal_sync_reg[0], terminal_run_i};
    end

    // writes; out-of-range link mode codes are refused, the fieldbus mode takes data bits 1:0 unchecked
    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            link_source_select_reg     <= `LINK_SEL_RST;
            fieldbus_source_select_reg <= `FBUS_SEL_RST;
            run_origin_param_reg       <= `RUN_ORIGIN_RST;
            permit_assigned_reg        <= `PERMIT_CFG_RST;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `ADDR_LINK_SEL:
                    if (wdata_i[3:0] <= `LINK_SEL_MAX && wdata_i[7:4] == 4'h0)
                        link_source_select_reg <= wdata_i[3:0];
                `ADDR_FBUS_SEL:
                    fieldbus_source_select_reg <= wdata_i[1:0];
                `ADDR_RUN_ORIGIN:
                    run_origin_param_reg <= wdata_i[0];
                `ADDR_PERMIT_CFG:
                    permit_assigned_reg <= wdata_i[0];
                default:
                    ;
            endcase
        end
    end

    // =========================================================
    // source decode
    reg  [1:0] link_freq_src;
    reg  [1:0] link_run_src;
    reg  [1:0] freq_src_next;
    reg  [1:0] run_src_next;
    wire       modes_effective;

    // unassigned permit means always effective; assigned needs shorted pin
    assign modes_effective = !permit_assigned_reg || permit_level;

    // link mode code to (frequency, run) source pair
    always @*
    begin
        link_freq_src = `SRC_LOCAL;
        link_run_src  = `SRC_LOCAL;
        case (link_source_select_reg)
            4'h0: begin link_freq_src = `SRC_LOCAL; link_run_src = `SRC_LOCAL; end
            4'h1: begin link_freq_src = `SRC_STD;   link_run_src = `SRC_LOCAL; end
            4'h2: begin link_freq_src = `SRC_LOCAL; link_run_src = `SRC_STD;   end
            4'h3: begin link_freq_src = `SRC_STD;   link_run_src = `SRC_STD;   end
            4'h4: begin link_freq_src = `SRC_EXT;   link_run_src = `SRC_LOCAL; end
            4'h5: begin link_freq_src = `SRC_EXT;   link_run_src = `SRC_STD;   end
            4'h6: begin link_freq_src = `SRC_LOCAL; link_run_src = `SRC_EXT;   end
            4'h7: begin link_freq_src = `SRC_STD;   link_run_src = `SRC_EXT;   end
            4'h8: begin link_freq_src = `SRC_EXT;   link_run_src = `SRC_EXT;   end
            default: begin link_freq_src = `SRC_LOCAL; link_run_src = `SRC_LOCAL; end
        endcase
    end

    // each command decided on its own; fieldbus bit wins for its command unless an assigned permit is open
    always @*
    begin
        freq_src_next = link_freq_src;
        run_src_next  = link_run_src;
        if (fieldbus_source_select_reg[`FBUS_FREQ_BIT])
            freq_src_next = `SRC_FBUS;
        if (fieldbus_source_select_reg[`FBUS_RUN_BIT])
            run_src_next = `SRC_FBUS;
        if (!modes_effective)
        begin
            freq_src_next = `SRC_LOCAL;
            run_src_next  = `SRC_LOCAL;
        end
    end

    // =========================================================
    // command muxes
    reg  [15:0] freq_next;
    reg         run_next;
    wire [15:0] local_freq;
    wire        local_run;

    assign local_freq = multistep_sel_i ? multistep_freq_i : local_freq_i;
    // terminals come through the synchroniser, so they lag the keypad by two cycles
    assign local_run  = run_origin_param_reg ? terminal_sync_reg[1] : keypad_run_i;

    // route the chosen source's value; local is the default so a stray code stays safe
    always @*
    begin
        case (freq_src_next)
            `SRC_STD:  freq_next = std_freq_i;
            `SRC_EXT:  freq_next = ext_freq_i;
            `SRC_FBUS: freq_next = fbus_freq_i;
            default:   freq_next = local_freq;
        endcase
        case (run_src_next)
            `SRC_STD:  run_next = std_run_i;
            `SRC_EXT:  run_next = ext_run_i;
            `SRC_FBUS: run_next = fbus_run_i;
            default:   run_next = local_run;
        endcase
    end

    // status layout: bit 5 effective, bit 4 synced permit, 3:2 run source, 1:0 freq source
    wire [7:0] status_word;
    assign status_word = {2'h0, modes_effective, permit_level, run_src_o, freq_src_o};

    // registered outputs; one cycle of latency keeps outputs glitch free
    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            freq_cmd_o      <= `FREQ_CMD_RST;
            run_cmd_o       <= `RUN_CMD_RST;
            freq_src_o      <= `SRC_LOCAL;
            run_src_o       <= `SRC_LOCAL;
            monitor_grant_o <= `SRC_LOCAL;
            rdata_o         <= `RDATA_IDLE;
        end
        else
        begin
            freq_cmd_o      <= freq_next;
            run_cmd_o       <= run_next;
            freq_src_o      <= freq_src_next;
            run_src_o       <= run_src_next;
            // monitor/parameter access follows the frequency link
            monitor_grant_o <= freq_src_next;
            if (rd_i)
            begin
                case (addr_i)
                    `ADDR_LINK_SEL:   rdata_o <= {4'h0, link_source_select_reg};
                    `ADDR_FBUS_SEL:   rdata_o <= {6'h00, fieldbus_source_select_reg};
                    `ADDR_RUN_ORIGIN: rdata_o <= {7'h00, run_origin_param_reg};
                    `ADDR_PERMIT_CFG: rdata_o <= {7'h00, permit_assigned_reg};
                    `ADDR_STATUS:     rdata_o <= status_word;
                    default:          rdata_o <= `RDATA_IDLE;
                endcase
            end
            else
                rdata_o <= `RDATA_IDLE;
        end
    end

endmodule // command_source_selector
`default_nettype wire

// [logic/source_sel_regs.vh]
`ifndef SOURCE_SEL_REGS_VH
`define SOURCE_SEL_REGS_VH
// register indices (byte address = index, plain port)
`define ADDR_LINK_SEL      4'h0
`define ADDR_FBUS_SEL      4'h1
`define ADDR_RUN_ORIGIN    4'h2
`define ADDR_PERMIT_CFG    4'h3
`define ADDR_STATUS        4'h4
// field widths and limits
`define LINK_SEL_MAX       4'h8
`define FBUS_SEL_MAX       2'h3
// source codes
`define SRC_LOCAL          2'h0
`define SRC_STD            2'h1
`define SRC_EXT            2'h2
`define SRC_FBUS           2'h3
// field bits of the fieldbus mode
`define FBUS_FREQ_BIT      0
`define FBUS_RUN_BIT       1
// reset values
`define LINK_SEL_RST       4'h0
`define FBUS_SEL_RST       2'h0
`define RUN_ORIGIN_RST     1'b0
`define PERMIT_CFG_RST     1'b0
`define SYNC_RST           2'h0
`define FREQ_CMD_RST       16'h0000
`define RUN_CMD_RST        1'b0
`define RDATA_IDLE         8'h00
`endif

// [verification/sel_props_properties.sv]
`default_nettype none
module sel_props
(
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    // register read side
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    // command inputs
    input wire logic        multistep_sel_i,
    input wire logic [15:0] local_freq_i,
    input wire logic [15:0] multistep_freq_i,
    input wire logic [15:0] std_freq_i,
    input wire logic [15:0] ext_freq_i,
    input wire logic [15:0] fbus_freq_i,
    input wire logic        std_run_i,
    input wire logic        ext_run_i,
    input wire logic        fbus_run_i,
    // selected outputs
    input wire logic [15:0] freq_cmd_o,
    input wire logic        run_cmd_o,
    input wire logic [1:0]  freq_src_o,
    input wire logic [1:0]  run_src_o,
    input wire logic [1:0]  monitor_grant_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // ==========================================
    // selection follows source one cycle late
    // the first edge after reset still shows reset values, so skip it
    sequence s_live;
        $past(resetn_i);
    endsequence
    a_freq_local: assert property (s_live ##0 freq_src_o == 2'h0 |->
        freq_cmd_o == $past(multistep_sel_i ? multistep_freq_i : local_freq_i)) else $error("local freq");
    a_freq_std: assert property (s_live ##0 freq_src_o == 2'h1 |->
        freq_cmd_o == $past(std_freq_i)) else $error("std freq");
    a_freq_ext: assert property (s_live ##0 freq_src_o == 2'h2 |->
        freq_cmd_o == $past(ext_freq_i)) else $error("ext freq");
    a_freq_fbus: assert property (s_live ##0 freq_src_o == 2'h3 |->
        freq_cmd_o == $past(fbus_freq_i)) else $error("fbus freq");
    a_run_std: assert property (s_live ##0 run_src_o == 2'h1 |->
        run_cmd_o == $past(std_run_i)) else $error("std run");
    a_run_ext: assert property (s_live ##0 run_src_o == 2'h2 |->
        run_cmd_o == $past(ext_run_i)) else $error("ext run");
    a_run_fbus: assert property (s_live ##0 run_src_o == 2'h3 |->
        run_cmd_o == $past(fbus_run_i)) else $error("fbus run");
    a_grant_tracks_freq: assert property (monitor_grant_o == freq_src_o)
        else $error("grant differs");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("rdata not idle");
endmodule // sel_props
bind command_source_selector sel_props sel_props_inst (.ref_clk_i, .resetn_i, .rd_i, .rdata_o,
    .multistep_sel_i, .local_freq_i, .multistep_freq_i, .std_freq_i, .ext_freq_i, .fbus_freq_i,
    .std_run_i, .ext_run_i, .fbus_run_i, .freq_cmd_o, .run_cmd_o, .freq_src_o, .run_src_o,
    .monitor_grant_o);
`default_nettype wire

// [verification/link_partner.sv]
`default_nettype none
module link_partner
(
    // clock and permit request
    input wire logic         ref_clk_i,
    input wire logic         permit_i,
    // remote commands and permit pin
    output var logic [15:0]  std_freq_o,
    output var logic [15:0]  ext_freq_o,
    output var logic [15:0]  fbus_freq_o,
    output var logic         std_run_o,
    output var logic         ext_run_o,
    output var logic         fbus_run_o,
    output var logic         permit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt = 16'h0000;
    // ==========================================
    // values move every cycle (fbus run every second cycle) so a stale capture shows up
    always @(posedge ref_clk_i) cnt <= cnt + 16'h0001;
    assign std_freq_o  = cnt + 16'h1000;
    assign ext_freq_o  = cnt + 16'h2000;
    assign fbus_freq_o = cnt + 16'h3000;
    assign std_run_o   = cnt[0];
    assign ext_run_o   = ~cnt[0];
    assign fbus_run_o  = cnt[1];
    assign permit_o    = permit_i;
endmodule // link_partner
`default_nettype wire

// [verification/tb.sv]
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, permit = 1;
    logic ms_sel = 0, key_run = 0, term_run = 0, sr, er, fr, pin, run_cmd;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata, d;
    logic [15:0] sf, ef, ff, freq_cmd;
    logic [1:0] fsrc, rsrc, grant;
    int failures = 0, tests_run = 0;
    // ==========================================
    initial forever #4 ref_clk_i = ~ref_clk_i;
    // watchdog: the tests need well under a thousand cycles, so this is ample
    initial
    begin
        #200000;
        failures++;
        results;
    end
    link_partner link_partner_inst (.ref_clk_i, .permit_i(permit), .std_freq_o(sf),
        .ext_freq_o(ef), .fbus_freq_o(ff), .std_run_o(sr), .ext_run_o(er), .fbus_run_o(fr),
        .permit_o(pin));
    command_source_selector command_source_selector_inst (.ref_clk_i, .resetn_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o(rdata), .remote_permit_input_i(pin),
        .local_freq_i(16'h0123), .multistep_freq_i(16'h0456), .multistep_sel_i(ms_sel),
        .keypad_run_i(key_run), .terminal_run_i(term_run), .std_freq_i(sf), .std_run_i(sr),
        .ext_freq_i(ef), .ext_run_i(er), .fbus_freq_i(ff), .fbus_run_i(fr),
        .freq_cmd_o(freq_cmd), .run_cmd_o(run_cmd), .freq_src_o(fsrc), .run_src_o(rsrc),
        .monitor_grant_o(grant));
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe; taken just after that edge
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // expected {run source, frequency source}
    function automatic logic [3:0] exp_src(input int l, input int f);
        logic [1:0] fs, rs;
        fs = (l == 1 || l == 3 || l == 7) ? 2'h1 : (l == 4 || l == 5 || l == 8) ? 2'h2 : 2'h0;
        rs = (l == 2 || l == 3 || l == 5) ? 2'h1 : (l >= 6) ? 2'h2 : 2'h0;
        if (f[0]) fs = 2'h3;
        if (f[1]) rs = 2'h3;
        return {rs, fs};
    endfunction
    task automatic t_modes;
        logic [3:0] e;
        for (int l = 0; l < 9; l++)
            for (int f = 0; f < 4; f++)
            begin
                wr(4'h0, 8'(l));
                wr(4'h1, 8'(f));
                settle(2);
                e = exp_src(l, f);
                `CHK({rsrc, fsrc}, e)
                `CHK(grant, e[1:0])
            end
    endtask
    task automatic t_refuse_and_status;
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h05);
        wr(4'h0, 8'h09);
        rd(4'h0);
        `CHK(d, 8'h05)
        rd(4'h4);
        `CHK(d, 8'h36)
        rd(4'hf);
        `CHK(d, 8'h00)
    endtask
    task automatic t_permit;
        wr(4'h0, 8'h07);
        wr(4'h1, 8'h03);
        permit <= 0;
        settle(5);
        `CHK({rsrc, fsrc}, 4'hf)
        wr(4'h3, 8'h01);
        settle(5);
        `CHK({rsrc, fsrc}, 4'h0)
        `CHK(freq_cmd, 16'h0123)
        rd(4'h4);
        `CHK(d, 8'h00)
        rd(4'h3);
        `CHK(d, 8'h01)
        permit <= 1;
        settle(5);
        `CHK({rsrc, fsrc}, 4'hf)
        rd(4'h4);
        `CHK(d, 8'h3f)
    endtask
    task automatic t_local;
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        key_run <= 1;
        ms_sel <= 1;
        settle(2);
        `CHK({run_cmd, freq_cmd}, 17'h10456)
        wr(4'h2, 8'h01);
        ms_sel <= 0;
        settle(2);
        `CHK({run_cmd, freq_cmd}, 17'h00123)
        key_run <= 0;
        term_run <= 1;
        // terminal level crosses a two-flop synchroniser before the output flop
        settle(4);
        `CHK({run_cmd, freq_cmd}, 17'h10123)
        rd(4'h2);
        `CHK(d, 8'h01)
    endtask
    // reset in mid-run: outputs clear at once and the mode registers return to defaults
    task automatic t_reset;
        wr(4'h0, 8'h03);
        settle(2);
        `CHK({rsrc, fsrc}, 4'h5)
        resetn_i <= 0;
        settle(2);
        `CHK({grant, rsrc, fsrc, run_cmd, freq_cmd}, 23'h000000)
        resetn_i <= 1;
        rd(4'h0);
        `CHK(d, 8'h00)
        settle(2);
        `CHK({rsrc, fsrc}, 4'h0)
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        settle(4);
        resetn_i <= 1;
        t_modes;
        t_refuse_and_status;
        t_permit;
        t_local;
        t_reset;
        results;
    end
endmodule // tb
`default_nettype wire
